/* File: core/bpg_top.sv */
// Board power glue: bus isolation switch, supply turn-on, power-good and clock guard.
// Assumes all pin inputs synchronous to mclk; open-drain pins resolved outside.
//
// Behaviour
// [R01] Switch closed while supply power-good high
// [R02] Switch open, no drive, while power-good low
// [R03] Closed switch carries a low across pairs
// [R04] Turn-on low only: processor present, S3 high
// [R05] Power-good out is supply AND debounced reset
// [R06] Debounce both edges, about 16ms stable
// [R07] Debounce timed by 32.768kHz tick count
// [R08] Qualification never shorter than 15.8ms
// [R09] Clock guard low while power-good out high
// [R10] Sampled differs from filtered restarts counter
`timescale 1ns/10ps
`include "bpg_consts.svh"

module bpg_top #(
   parameter int unsigned DIV_CYCLES = `BPG_DIV_CYCLES
) (
   input  wire logic  mclk,
   input  wire logic  rst_n,
   // Isolation switch pins, main-well side
   input  wire logic  main_bus_clock_pin_i,
   output wire logic  main_bus_clock_pin_o,
   output wire logic  main_bus_clock_pin_oe,
   input  wire logic  main_bus_data_pin_i,
   output wire logic  main_bus_data_pin_o,
   output wire logic  main_bus_data_pin_oe,
   // Isolation switch pins, resume-well side
   input  wire logic  resume_bus_clock_pin_i,
   output wire logic  resume_bus_clock_pin_o,
   output wire logic  resume_bus_clock_pin_oe,
   input  wire logic  resume_bus_data_pin_i,
   output wire logic  resume_bus_data_pin_o,
   output wire logic  resume_bus_data_pin_oe,
   // Power state inputs
   input  wire logic  supply_power_good_in,
   input  wire logic  processor_present_n,
   input  wire logic  sleep_state3_n,
   input  wire logic  front_panel_reset_n,
   // Supply turn-on, open drain
   output wire logic  supply_turn_on_n_o,
   output wire logic  supply_turn_on_n_oe,
   // Power-good, push-pull
   output wire logic  power_good_out,
   // Clock guard gate, open drain
   output wire logic  clock_guard_gate_o,
   output wire logic  clock_guard_gate_oe
);
   import bpg_pkg::*;

   bpg_top_reg_t             q;
   bpg_top_reg_t             d;
   logic [`BPG_PAIRS-1:0]    main_in;
   logic [`BPG_PAIRS-1:0]    res_in;
   logic [`BPG_PAIRS-1:0]    drv_main_d;
   logic [`BPG_PAIRS-1:0]    drv_res_d;
   logic                     switch_on;

   bpg_deb_if dbi ();

   // ****************************************************************
   // Slow tick and debouncer
   // ****************************************************************
   assign dbi.tick  = q.tick;
   assign dbi.raw_n = front_panel_reset_n;

   bpg_debounce u_debounce (
      .mclk  (mclk),
      .rst_n (rst_n),
      .dbi   (dbi)
   );

   // ****************************************************************
   // Isolation switch
   // ****************************************************************
   assign switch_on = supply_power_good_in;                          // [R01]

   assign main_in[`BPG_PAIR_CLK] = main_bus_clock_pin_i;
   assign main_in[`BPG_PAIR_DAT] = main_bus_data_pin_i;
   assign res_in[`BPG_PAIR_CLK]  = resume_bus_clock_pin_i;
   assign res_in[`BPG_PAIR_DAT]  = resume_bus_data_pin_i;

   // A side is pulled low only when the other side is held low by someone else.
   // Our own drive never feeds back, so the pair cannot latch itself low, and a
   // low seen on both sides at once is left to the external drivers.
   genvar gp;
   generate
      for (gp = 0; gp < `BPG_PAIRS; gp++) begin : g_pair
         assign drv_main_d[gp] = switch_on & ~res_in[gp] & ~q.drv_res[gp]
                                 & (main_in[gp] | q.drv_main[gp]);  // [R03]
         assign drv_res_d[gp]  = switch_on & ~main_in[gp] & ~q.drv_main[gp]
                                 & (res_in[gp] | q.drv_res[gp]);    // [R03]
      end
   endgenerate

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      d = q;
      if (q.div_cnt == `BPG_DIV_W'(DIV_CYCLES - 1)) begin
         d.div_cnt = '0;
         d.tick    = 1'h1;                                           // [R07]
      end else begin
         d.div_cnt = q.div_cnt + `BPG_DIV_W'(1);
         d.tick    = 1'h0;
      end
      // Switch open: no drive on either side
      d.drv_main = switch_on ? drv_main_d : '0;                      // [R02]
      d.drv_res  = switch_on ? drv_res_d : '0;                       // [R02]
      d.ps_on_oe = ~processor_present_n & sleep_state3_n;           // [R04]
      d.pgood    = supply_power_good_in & dbi.level_n;              // [R05]
      // Taken from the same next value so the gate never lags power-good
      d.gate_oe  = d.pgood;                                          // [R09]
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ****************************************************************
   // Pin drive; open-drain outputs only ever pull low
   // ****************************************************************
   assign main_bus_clock_pin_o    = 1'h0;
   assign main_bus_clock_pin_oe   = q.drv_main[`BPG_PAIR_CLK];
   assign main_bus_data_pin_o     = 1'h0;
   assign main_bus_data_pin_oe    = q.drv_main[`BPG_PAIR_DAT];
   assign resume_bus_clock_pin_o  = 1'h0;
   assign resume_bus_clock_pin_oe = q.drv_res[`BPG_PAIR_CLK];
   assign resume_bus_data_pin_o   = 1'h0;
   assign resume_bus_data_pin_oe  = q.drv_res[`BPG_PAIR_DAT];
   assign supply_turn_on_n_o      = 1'h0;
   assign supply_turn_on_n_oe     = q.ps_on_oe;
   assign power_good_out          = q.pgood;
   assign clock_guard_gate_o      = 1'h0;
   assign clock_guard_gate_oe     = q.gate_oe;

endmodule

/* File: core/bpg_consts.svh */
// Constants of the board power glue block: clock rates, timing counts, pin-pair indices.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef BPG_CONSTS_SVH
`define BPG_CONSTS_SVH

// ****************************************************************
// Clock rates
// ****************************************************************
`define BPG_MCLK_HZ     32'h0EE6_B280
`define BPG_SLOW_HZ     32'h0000_8000
`define BPG_US_PER_S    32'h000F_4240
// Whole mclk cycles per slow-clock tick, rounded down
`define BPG_DIV_CYCLES  (`BPG_MCLK_HZ / `BPG_SLOW_HZ)
`define BPG_DIV_W       13

// ****************************************************************
// Front-panel reset debounce
// ****************************************************************
`define BPG_DEB_NOM_US  32'h0000_3E80
`define BPG_DEB_MIN_US  32'h0000_3DB8
// Ticks rounded up, plus one tick for the unknown phase of the first one
`define BPG_DEB_TICKS   (((`BPG_DEB_MIN_US * `BPG_SLOW_HZ) + `BPG_US_PER_S - 32'h0000_0001) \
                         / `BPG_US_PER_S + 32'h0000_0001)
`define BPG_DEB_W       10
// Filtered level after reset: treated as pressed until qualified
`define BPG_DEB_RST     1'h0

// ****************************************************************
// Bus isolation switch pairs
// ****************************************************************
`define BPG_PAIRS       2
`define BPG_PAIR_CLK    0
`define BPG_PAIR_DAT    1

`endif

/* File: core/bpg_pkg.sv */
// Types of the board power glue block: debounce states and register images.
// Assumes bpg_consts.svh on the include path.
`include "bpg_consts.svh"

package bpg_pkg;

   typedef enum logic [0:0] {
      BPG_DEB_STABLE = 1'h0,
      BPG_DEB_QUAL   = 1'h1
   } bpg_deb_state_t;

   typedef struct packed {
      logic                    sync1;
      logic                    sync2;
      logic                    samp;
      logic                    filt;
      bpg_deb_state_t          st;
      logic [`BPG_DEB_W-1:0]   cnt;
   } bpg_deb_reg_t;

   typedef struct packed {
      logic [`BPG_DIV_W-1:0]   div_cnt;
      logic                    tick;
      logic [`BPG_PAIRS-1:0]   drv_main;
      logic [`BPG_PAIRS-1:0]   drv_res;
      logic                    ps_on_oe;
      logic                    pgood;
      logic                    gate_oe;
   } bpg_top_reg_t;

endpackage

/* File: core/bpg_deb_if.sv */
// Link between the glue top and its front-panel reset debouncer.
// Assumes both ends run on mclk; tick is a one-cycle enable at the slow rate.
`timescale 1ns/10ps

interface bpg_deb_if;
   logic tick;
   logic raw_n;
   logic level_n;

   modport deb (
      input  tick,
      input  raw_n,
      output level_n
   );

   modport ctl (
      output tick,
      output raw_n,
      input  level_n
   );
endinterface

/* File: core/bpg_debounce.sv */
// Front-panel reset debouncer: synchroniser, slow-tick sampler and qualification counter.
// Assumes mclk with synchronous active-low reset and a one-cycle tick from the top.
`timescale 1ns/10ps
`include "bpg_consts.svh"

module bpg_debounce (
   input wire logic  mclk,
   input wire logic  rst_n,
   bpg_deb_if.deb    dbi
);
   import bpg_pkg::*;

   bpg_deb_reg_t q;
   bpg_deb_reg_t d;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      d       = q;
      d.sync1 = dbi.raw_n;
      d.sync2 = q.sync1;
      if (dbi.tick) begin
         d.samp = q.sync2;                                           // [R07]
         case (q.st)
            BPG_DEB_STABLE: begin
               if (q.samp != q.filt) begin                           // [R10]
                  d.st  = BPG_DEB_QUAL;
                  d.cnt = `BPG_DEB_W'(1);
               end
            end
            BPG_DEB_QUAL: begin
               if (q.samp == q.filt) begin
                  // Any bounce back restarts qualification
                  d.st  = BPG_DEB_STABLE;                            // [R10]
                  d.cnt = '0;
               end else if (q.cnt == `BPG_DEB_W'(`BPG_DEB_TICKS - 1)) begin
                  // Same path for both edges
                  d.filt = q.samp;                                   // [R06]
                  d.st   = BPG_DEB_STABLE;                           // [R08]
                  d.cnt  = '0;
               end else begin
                  d.cnt = q.cnt + `BPG_DEB_W'(1);
               end
            end
            default: begin
               d.st  = BPG_DEB_STABLE;
               d.cnt = '0;
            end
         endcase
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         q      <= '0;
         q.filt <= `BPG_DEB_RST;
      end else begin
         q <= d;
      end
   end

   assign dbi.level_n = q.filt;

endmodule

/* File: sim/bpg_top_properties.sv */
// Port-level checker for the board power glue top.
// Assumes bpg_consts.svh on the include path; bound into bpg_top.
`timescale 1ns/10ps
`include "bpg_consts.svh"
module bpg_top_properties #(
   parameter int unsigned DIV_CYCLES = `BPG_DIV_CYCLES
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic main_bus_clock_pin_i,
   input wire logic main_bus_clock_pin_oe,
   input wire logic main_bus_data_pin_i,
   input wire logic main_bus_data_pin_oe,
   input wire logic resume_bus_clock_pin_i,
   input wire logic resume_bus_clock_pin_oe,
   input wire logic resume_bus_data_pin_i,
   input wire logic resume_bus_data_pin_oe,
   input wire logic supply_power_good_in,
   input wire logic processor_present_n,
   input wire logic sleep_state3_n,
   input wire logic front_panel_reset_n,
   input wire logic supply_turn_on_n_oe,
   input wire logic power_good_out,
   input wire logic clock_guard_gate_oe
);
   // ****************
   // Run counters
   // ****************
   // Margins cover the unknown tick phase and the synchroniser
   localparam int MIN_HI = (`BPG_DEB_TICKS - 1) * DIV_CYCLES;
   localparam int MAX_LO = (`BPG_DEB_TICKS + 2) * DIV_CYCLES + 6;
   int hi_run_q;
   int lo_run_q;
   always_ff @(posedge mclk) begin
      hi_run_q <= (!rst_n || !front_panel_reset_n) ? 0 : hi_run_q + 1;
      lo_run_q <= (!rst_n || front_panel_reset_n) ? 0 : lo_run_q + 1;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence res_clk_low_s;
      supply_power_good_in && !resume_bus_clock_pin_i && !resume_bus_clock_pin_oe
      && main_bus_clock_pin_i;
   endsequence
   sequence main_dat_low_s;
      supply_power_good_in && !main_bus_data_pin_i && !main_bus_data_pin_oe
      && resume_bus_data_pin_i;
   endsequence
   switch_open_a: assert property (!supply_power_good_in |=> !(main_bus_clock_pin_oe
      || main_bus_data_pin_oe || resume_bus_clock_pin_oe || resume_bus_data_pin_oe))
      else $error("switch not open");
   clk_carry_a: assert property (res_clk_low_s |=> main_bus_clock_pin_oe)
      else $error("clock low not carried");
   dat_carry_a: assert property (main_dat_low_s |=> resume_bus_data_pin_oe)
      else $error("data low not carried");
   no_echo_a: assert property (main_bus_data_pin_oe |-> !resume_bus_data_pin_oe)
      else $error("both sides driven");
   turn_on_map_a: assert property ($past(rst_n) |-> supply_turn_on_n_oe ==
      (!$past(processor_present_n) && $past(sleep_state3_n))) else $error("turn-on decode");
   pgood_and_a: assert property (power_good_out |-> $past(supply_power_good_in))
      else $error("power good without supply");
   gate_follow_a: assert property (clock_guard_gate_oe == power_good_out)
      else $error("gate not following");
   // Only a rise caused by the filtered level; a supply rise may follow a short glitch
   deb_min_a: assert property ($rose(power_good_out)
      && $past(supply_power_good_in, 2) |-> hi_run_q >= MIN_HI)
      else $error("debounce too short");
   deb_max_a: assert property (power_good_out |-> lo_run_q <= MAX_LO)
      else $error("debounce too long");
endmodule
bind bpg_top bpg_top_properties #(.DIV_CYCLES(DIV_CYCLES)) u_bpg_top_properties (.*);

/* File: sim/bpg_far_side.sv */
// Far side: bus pull-ups, other bus masters and open-drain pull-ups.
// Assumes pin order main clock, main data, resume clock, resume data.
`timescale 1ns/10ps
module bpg_far_side (
   input  wire logic [3:0] dev_oe,
   input  wire logic [3:0] ext_low,
   input  wire logic       ton_oe,
   input  wire logic       gate_oe,
   output wire logic [3:0] bus_lvl,
   output wire logic       ton_lvl,
   output wire logic       gate_lvl
);
   // Pull-up wins unless any party pulls low
   assign bus_lvl  = ~(dev_oe | ext_low);
   assign ton_lvl  = ~ton_oe;
   assign gate_lvl = ~gate_oe;
endmodule

/* File: sim/board_power_glue_logic_tb.sv */
// Testbench of the board power glue top with a short slow-tick divider.
// Assumes the far-side model and the bound checker are compiled alongside.
`timescale 1ns/10ps
module board_power_glue_logic_tb;
   logic       mclk = 0, rst_n = 0, pg = 0, cpu_n = 1, s3_n = 0, fp_n = 1;
   logic [3:0] ext_low = '0;
   wire  [3:0] oe, lvl;
   wire  [5:0] od;
   wire        ton_oe, gate_oe, ton_lvl, gate_lvl, pgood;
   int         bad_count = 0, n_tests = 0, n;
   always #2 mclk = ~mclk;
   bpg_top #(.DIV_CYCLES(4)) u_bpg_top (.mclk, .rst_n,
      .main_bus_clock_pin_i(lvl[0]), .main_bus_clock_pin_o(od[0]), .main_bus_clock_pin_oe(oe[0]),
      .main_bus_data_pin_i(lvl[1]), .main_bus_data_pin_o(od[1]), .main_bus_data_pin_oe(oe[1]),
      .resume_bus_clock_pin_i(lvl[2]), .resume_bus_clock_pin_o(od[2]),
      .resume_bus_clock_pin_oe(oe[2]), .resume_bus_data_pin_i(lvl[3]),
      .resume_bus_data_pin_o(od[3]), .resume_bus_data_pin_oe(oe[3]),
      .supply_power_good_in(pg), .processor_present_n(cpu_n), .sleep_state3_n(s3_n),
      .front_panel_reset_n(fp_n), .supply_turn_on_n_o(od[4]), .supply_turn_on_n_oe(ton_oe),
      .power_good_out(pgood), .clock_guard_gate_o(od[5]), .clock_guard_gate_oe(gate_oe));
   bpg_far_side u_bpg_far_side (.dev_oe(oe), .ext_low, .ton_oe, .gate_oe,
      .bus_lvl(lvl), .ton_lvl, .gate_lvl);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(negedge mclk);
   endtask
   // Edge count until power good reaches a level, bounded
   task automatic wait_pg(input logic val);
      n = 0;
      while (pgood !== val && n < 3000) begin
         tick(1);
         n++;
      end
   endtask
   task automatic t_switch();
      check({pgood, ton_oe, gate_oe, oe}, 7'h00);
      pg = 1;
      ext_low = 4'h4;
      tick(3);
      check({lvl, oe}, {4'hA, 4'h1});
      check(od, 6'h00);
      ext_low = 4'h2;
      tick(3);
      check({lvl, oe}, {4'h5, 4'h8});
      ext_low = 4'h8;
      tick(3);
      check({lvl, oe}, {4'h5, 4'h2});
      pg = 0;
      ext_low = 4'h4;
      tick(3);
      check({lvl, oe}, {4'hB, 4'h0});
      ext_low = 4'h0;
   endtask
   task automatic t_turn_on();
      for (int i = 0; i < 4; i++) begin
         {cpu_n, s3_n} = i[1:0];
         tick(2);
         check(ton_lvl, i != 1);
      end
   endtask
   task automatic t_pgood();
      fp_n = 0;
      pg = 1;
      tick(10);
      fp_n = 1;
      wait_pg(1);
      check(n >= 2072 && n <= 2104, 1);
      check({pgood, gate_lvl}, 2'h2);
      pg = 0;
      tick(2);
      check({pgood, gate_lvl}, 2'h1);
      pg = 1;
      tick(2);
      check(pgood, 1);
      fp_n = 0;
      tick(200);
      fp_n = 1;
      tick(2300);
      check(pgood, 1);
      fp_n = 0;
      wait_pg(0);
      check(n >= 2072 && n <= 2104, 1);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      tick(5);
      rst_n = 1;
      t_switch();
      t_turn_on();
      t_pgood();
      tally_and_finish();
   end
   // Tests need about 7000 cycles
   initial begin
      #80000;
      bad_count++;
      tally_and_finish();
   end
endmodule
